// ### logic/utf_pkg.sv
/*
 package for the transmit path with flow control: register map, fields, reset values,
 bit timing and state types. assumes an apb master on ref_clk and a receive path that
 hands finished characters and its fifo occupancy to this block.
*/
package utf_pkg;

	// ==========================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_HOLD = 8'h00;
	localparam logic [7:0] ADDR_IER = 8'h04;
	localparam logic [7:0] ADDR_IIR = 8'h08;
	localparam logic [7:0] ADDR_FCR = 8'h0C;
	localparam logic [7:0] ADDR_LCR = 8'h10;
	localparam logic [7:0] ADDR_MCR = 8'h14;
	localparam logic [7:0] ADDR_LSR = 8'h18;
	localparam logic [7:0] ADDR_EFR = 8'h1C;
	localparam logic [7:0] ADDR_RES1 = 8'h20;
	localparam logic [7:0] ADDR_RES2 = 8'h24;
	localparam logic [7:0] ADDR_PAU1 = 8'h28;
	localparam logic [7:0] ADDR_PAU2 = 8'h2C;
	localparam logic [7:0] ADDR_DIV = 8'h30;

	// ==========================================
	// field positions
	localparam int FCR_FIFO_EN = 0;
	localparam int FCR_DMA_MODE = 3;
	localparam int FCR_THR_LO = 4;
	localparam int IER_THR = 1;
	localparam int IER_PAUSE = 5;
	localparam int IER_CTS = 7;
	localparam int EFR_DOUBLE = 0;
	localparam int EFR_SWFC = 1;
	localparam int EFR_ARTS = 6;
	localparam int EFR_ACTS = 7;
	localparam int MCR_RTS = 1;
	localparam int LCR_STOP = 2;
	localparam int LCR_PAR_EN = 3;
	localparam int LCR_PAR_EVEN = 4;
	localparam int LSR_THRE = 5;
	localparam int LSR_TEMT = 6;
	localparam int IIR_THR = 1;
	localparam int IIR_SPECIAL = 4;
	localparam int IIR_FLOW = 5;

	// ==========================================
	// timing and reset values
	localparam logic [3:0] TICKS_PER_BIT = 4'hF;
	localparam logic [15:0] DIV_RESET = 16'h0001;
	localparam logic [7:0] CHAR_RESET = 8'h00;
	localparam logic [7:0] LCR_RESET = 8'h03;

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} utf_tx_type;
	typedef enum logic [1:0] {FC_NONE, FC_FIRST, FC_SECOND} utf_send_type;

	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} utf_char_type;

endpackage : utf_pkg

// ### logic/utf_tx.sv
/*
 transmit path of one serial channel: holding register and fifo, framer at the 16x rate,
 dma request, transmit interrupt, auto clear-to-send, auto request-to-send and software
 pause/resume control. assumes the receive path on the same clock delivers each received
 character as a one-cycle strobe and reports its fifo occupancy and trigger selection.
*/
// Decided for this implementation: the APB register port and the placing of the registers.
module utf_tx
#(
	parameter int DEPTH = 64,
	parameter bit DEEP = 1'b1
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// receive path side
	input utf_pkg::utf_char_type rx_char,
	input wire logic [6:0] rx_count,
	input wire logic [1:0] rx_trig_sel,
	output logic rx_char_keep,
	// line side
	input wire logic cts_n,
	output logic sout,
	output logic rts_n,
	// dma and interrupt
	output logic tx_dma_request,
	output logic interrupt_out
);
	import utf_pkg::*;

	localparam int AW = $clog2(DEPTH);

	// ==========================================
	// state
	typedef struct packed {
		logic [7:0] interrupt_enable_reg, fifo_control_reg, lcr, modem_control_reg, enhanced_feature_reg, res1, res2, pau1, pau2;
		logic [15:0] div, divcnt;
		logic [AW-1:0] wp, rp;
		logic [AW:0] cnt;
		logic [7:0] shift;
		logic [2:0] bitn;
		logic [3:0] tick;
		logic par;
		logic stop2;
		utf_tx_type st;
		logic thr_int, flow_int, special_int, pause_int;
		logic [1:0] hyst;
		logic paused;
		logic [7:0] prev_rx;
		logic prev_ok;
		utf_send_type fc_send;
		logic fc_off;
		logic rts_hold;
		logic dma_single;
		logic dma_burst;
		logic cts_a, cts_s, cts_prev;
		logic [31:0] rdata;
	} utf_state_type;

	utf_state_type q, d;
	logic [7:0] mem_q [DEPTH];
	logic push, pop, thr_empty, can_start, free_gt, hi_hit, lo_hit, rd_iir, fc_char;
	logic [AW:0] free, thresh;
	logic [6:0] up_lvl, lo_lvl, rts_off, rts_on;
	logic [7:0] send_byte;
	logic [2:0] nbits;

	always_ff @(posedge ref_clk)
		if (push)
			mem_q[q.wp] <= pwdata[7:0];

	always_comb
	begin
		d = q;
		push = psel && penable && pwrite && paddr == ADDR_HOLD && q.cnt != (AW+1)'(DEPTH);
		rd_iir = psel && penable && !pwrite && paddr == ADDR_IIR;
		free = (AW+1)'(DEPTH) - q.cnt;
		thresh = DEEP ? (AW+1)'({q.fifo_control_reg[FCR_THR_LO+1:FCR_THR_LO], 3'h0}) : (AW+1)'(DEPTH - 1);
		free_gt = free > thresh;
		nbits = 3'(4 + q.lcr[1:0]);
		// deep and shallow trigger tables for software and hardware flow
		unique case (rx_trig_sel)
			2'd0:
			begin
				up_lvl = DEEP ? 7'd8 : 7'd1;
				lo_lvl = 7'd0;
				rts_off = DEEP ? 7'd16 : 7'd2;
				rts_on = 7'd0;
			end
			2'd1:
			begin
				up_lvl = DEEP ? 7'd16 : 7'd4;
				lo_lvl = DEEP ? 7'd8 : 7'd1;
				rts_off = DEEP ? 7'd56 : 7'd8;
				rts_on = DEEP ? 7'd8 : 7'd1;
			end
			2'd2:
			begin
				up_lvl = DEEP ? 7'd56 : 7'd8;
				lo_lvl = DEEP ? 7'd16 : 7'd4;
				rts_off = DEEP ? 7'd60 : 7'd14;
				rts_on = DEEP ? 7'd16 : 7'd4;
			end
			default:
			begin
				up_lvl = DEEP ? 7'd60 : 7'd14;
				lo_lvl = DEEP ? 7'd56 : 7'd8;
				rts_off = DEEP ? 7'd60 : 7'd14;
				rts_on = DEEP ? 7'd56 : 7'd8;
			end
		endcase
		hi_hit = rx_count >= up_lvl;
		lo_hit = rx_count <= lo_lvl;

		// ==========================================
		// register writes
		if (psel && penable && pwrite)
			unique case (paddr)
				ADDR_IER: d.interrupt_enable_reg = pwdata[7:0];
				ADDR_FCR: d.fifo_control_reg = pwdata[7:0];
				ADDR_LCR: d.lcr = pwdata[7:0];
				ADDR_MCR: d.modem_control_reg = pwdata[7:0];
				ADDR_EFR: d.enhanced_feature_reg = pwdata[7:0];
				ADDR_RES1: d.res1 = pwdata[7:0];
				ADDR_RES2: d.res2 = pwdata[7:0];
				ADDR_PAU1: d.pau1 = pwdata[7:0];
				ADDR_PAU2: d.pau2 = pwdata[7:0];
				ADDR_DIV: d.div = pwdata[15:0];
				default: ;
			endcase

		// ==========================================
		// 16x tick and framer
		d.divcnt = (q.divcnt + 16'h0001 >= q.div) ? 16'h0000 : q.divcnt + 16'h0001;
		can_start = q.cnt != '0 && !q.paused && !(q.enhanced_feature_reg[EFR_ACTS] && q.cts_s)
			&& q.fc_send == FC_NONE;
		send_byte = q.fc_off ? (q.fc_send == FC_FIRST ? q.pau1 : q.pau2)
			: (q.fc_send == FC_FIRST ? q.res1 : q.res2);
		pop = 1'b0;
		if (q.divcnt == 16'h0000)
		begin
			d.tick = q.tick + 4'h1;
			unique case (q.st)
				ST_IDLE:
				begin
					d.tick = 4'h0;
					if (q.fc_send != FC_NONE)
					begin
						d.shift = send_byte;
						d.st = ST_START;
						d.fc_send = q.fc_send == FC_FIRST ? FC_SECOND : FC_NONE;
					end
					else if (can_start)
					begin
						d.shift = mem_q[q.rp];
						pop = 1'b1;
						d.st = ST_START;
					end
					d.par = !q.lcr[LCR_PAR_EVEN];
				end
				ST_START:
					if (q.tick == TICKS_PER_BIT)
					begin
						d.st = ST_DATA;
						d.bitn = 3'h0;
					end
				ST_DATA:
					if (q.tick == TICKS_PER_BIT)
					begin
						d.par = q.par ^ q.shift[0];
						d.shift = {1'b0, q.shift[7:1]};
						d.bitn = q.bitn + 3'h1;
						if (q.bitn == nbits)
							d.st = q.lcr[LCR_PAR_EN] ? ST_PAR : ST_STOP;
						d.stop2 = q.lcr[LCR_STOP];
					end
				ST_PAR:
					if (q.tick == TICKS_PER_BIT)
						d.st = ST_STOP;
				ST_STOP:
					if (q.tick == TICKS_PER_BIT)
					begin
						d.stop2 = 1'b0;
						if (!q.stop2)
							d.st = ST_IDLE;
					end
			endcase
		end

		// ==========================================
		// fifo pointers; non-fifo mode is a one-deep fifo
		if (push)
			d.wp = q.fifo_control_reg[FCR_FIFO_EN] ? q.wp + AW'(1) : q.rp;
		if (pop)
			d.rp = q.fifo_control_reg[FCR_FIFO_EN] ? q.rp + AW'(1) : q.rp;
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		thr_empty = q.fifo_control_reg[FCR_FIFO_EN] ? (DEEP ? free_gt : q.cnt == '0) : q.cnt == '0;

		// ==========================================
		// transmit interrupt with write hysteresis: two writes in fifo mode, one in non-fifo mode
		if (push && q.hyst != 2'd2)
			d.hyst = q.hyst + 2'd1;
		if (push || rd_iir)
			d.thr_int = 1'b0;
		if (q.interrupt_enable_reg[IER_THR] && thr_empty && q.hyst == 2'd2 && !push && !q.thr_int
			&& (DEEP || q.cnt == '0 || !q.fifo_control_reg[FCR_FIFO_EN]))
		begin
			d.thr_int = 1'b1;
			// non-fifo re-arms on one write, so an ident read stays cleared
			d.hyst = q.fifo_control_reg[FCR_FIFO_EN] ? 2'd0 : 2'd1;
		end

		// ==========================================
		// dma request
		if (q.fifo_control_reg[FCR_DMA_MODE])
			d.dma_single = 1'b0;
		else if (push)
			d.dma_single = 1'b0;
		else if (q.cnt == '0)
			d.dma_single = 1'b1;
		// burst request holds from threshold down to full, so one request fills the fifo
		if (free == '0)
			d.dma_burst = 1'b0;
		else if (DEEP ? free_gt : q.cnt == '0)
			d.dma_burst = 1'b1;

		// ==========================================
		// clear-to-send
		d.cts_a = cts_n;
		d.cts_s = q.cts_a;
		d.cts_prev = q.cts_s;
		if (rd_iir)
			d.flow_int = 1'b0;
		if (q.enhanced_feature_reg[EFR_ACTS] && q.interrupt_enable_reg[IER_CTS] && q.cts_s && !q.cts_prev)
			d.flow_int = 1'b1;

		// ==========================================
		// software flow: received character matching
		fc_char = 1'b0;
		if (rd_iir)
			d.pause_int = 1'b0;
		if (rx_char.valid && q.enhanced_feature_reg[EFR_SWFC])
		begin
			d.prev_rx = rx_char.data;
			d.prev_ok = !q.prev_ok || !q.enhanced_feature_reg[EFR_DOUBLE];
			if (q.enhanced_feature_reg[EFR_DOUBLE] ? (q.prev_ok && q.prev_rx == q.pau1 && rx_char.data == q.pau2)
				: (rx_char.data == q.pau1 || rx_char.data == q.pau2))
			begin
				d.paused = 1'b1;
				d.special_int = 1'b1;
				d.pause_int = q.interrupt_enable_reg[IER_PAUSE] | d.pause_int;
				fc_char = 1'b1;
			end
			if (q.enhanced_feature_reg[EFR_DOUBLE] ? (q.prev_ok && q.prev_rx == q.res1 && rx_char.data == q.res2)
				: (rx_char.data == q.res1 || rx_char.data == q.res2))
			begin
				d.paused = 1'b0;
				d.special_int = 1'b0;
				fc_char = 1'b1;
			end
			if (q.enhanced_feature_reg[EFR_DOUBLE] && !q.prev_ok && (rx_char.data == q.pau1 || rx_char.data == q.res1))
				fc_char = 1'b1;
		end
		if (!q.enhanced_feature_reg[EFR_SWFC])
			d.paused = 1'b0;

		// ==========================================
		// software flow: sending pause or resume
		if (q.enhanced_feature_reg[EFR_SWFC] && q.fc_send == FC_NONE && q.st == ST_IDLE)
		begin
			if (hi_hit && !q.fc_off)
			begin
				d.fc_send = FC_FIRST;
				d.fc_off = 1'b1;
			end
			else if (lo_hit && q.fc_off)
			begin
				d.fc_send = FC_FIRST;
				d.fc_off = 1'b0;
			end
		end

		// ==========================================
		// auto request-to-send hold-off
		if (rx_count >= rts_off)
			d.rts_hold = 1'b1;
		else if (rx_count <= rts_on)
			d.rts_hold = 1'b0;

		// ==========================================
		// read data
		d.rdata = 32'h00000000;
		if (psel && !penable && !pwrite)
			unique case (paddr)
				ADDR_IER: d.rdata = {24'h000000, q.interrupt_enable_reg};
				ADDR_IIR: d.rdata = {26'h0000000, q.flow_int, q.special_int, 2'b00,
					q.thr_int, !(q.thr_int || q.flow_int || q.pause_int)};
				ADDR_FCR: d.rdata = {24'h000000, q.fifo_control_reg};
				ADDR_LCR: d.rdata = {24'h000000, q.lcr};
				ADDR_MCR: d.rdata = {24'h000000, q.modem_control_reg};
				ADDR_LSR: d.rdata = {25'h0000000, q.cnt == '0 && q.st == ST_IDLE, thr_empty, 5'h00};
				ADDR_EFR: d.rdata = {24'h000000, q.enhanced_feature_reg};
				ADDR_RES1: d.rdata = {24'h000000, q.res1};
				ADDR_RES2: d.rdata = {24'h000000, q.res2};
				ADDR_PAU1: d.rdata = {24'h000000, q.pau1};
				ADDR_PAU2: d.rdata = {24'h000000, q.pau2};
				ADDR_DIV: d.rdata = {16'h0000, q.div};
				default: d.rdata = 32'h00000000;
			endcase
	end

	// ==========================================
	// registers
	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn)
		begin
			q <= '0;
			q.lcr <= LCR_RESET;
			q.div <= DIV_RESET;
			q.hyst <= 2'd2;
			q.dma_single <= 1'b1;
			q.cts_a <= 1'b1;
			q.cts_s <= 1'b1;
			q.cts_prev <= 1'b1;
			q.res1 <= CHAR_RESET;
			q.pau1 <= CHAR_RESET;
		end
		else
			q <= d;

	// ==========================================
	// outputs
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = q.rdata;
	assign rx_char_keep = rx_char.valid && !fc_char;
	assign sout = (q.st == ST_START) ? 1'b0 : (q.st == ST_DATA) ? q.shift[0]
		: (q.st == ST_PAR) ? q.par : 1'b1;
	assign rts_n = !(q.modem_control_reg[MCR_RTS] && !(q.enhanced_feature_reg[EFR_ARTS] && q.rts_hold));
	assign tx_dma_request = q.fifo_control_reg[FCR_DMA_MODE] ? (q.dma_burst && free != '0)
		: q.dma_single;
	assign interrupt_out = q.thr_int || q.flow_int || q.pause_int;

	// ==========================================
	// assertions
	a_bit_length: assert property (@(posedge ref_clk) disable iff (!resetn)
		q.st == ST_START && q.tick == 4'h0 && q.divcnt == 16'h0000 && q.div == 16'h0001
		|-> ##15 q.st == ST_START ##1 q.st == ST_DATA) else $error("bit time wrong");
	a_start_low: assert property (@(posedge ref_clk) disable iff (!resetn)
		q.st == ST_START |-> sout == 1'b0) else $error("start bit not low");
	a_push_count: assert property (@(posedge ref_clk) disable iff (!resetn)
		push && !pop |=> q.cnt == $past(q.cnt) + (AW+1)'(1)) else $error("push lost");
	a_thr_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		push |=> !q.thr_int) else $error("holding write kept interrupt");
	a_paused_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		q.paused && q.st == ST_IDLE && q.fc_send == FC_NONE |=> q.st == ST_IDLE)
		else $error("sent while paused");
	a_cts_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		q.enhanced_feature_reg[EFR_ACTS] && q.cts_s && q.st == ST_IDLE && q.fc_send == FC_NONE |-> !pop)
		else $error("sent while clear-to-send high");
	a_idle_mark: assert property (@(posedge ref_clk) disable iff (!resetn)
		q.st == ST_IDLE |-> sout) else $error("idle line not mark");
	a_keep_flow: assert property (@(posedge ref_clk) disable iff (!resetn)
		fc_char |-> !rx_char_keep) else $error("flow char passed");
	a_rts_req: assert property (@(posedge ref_clk) disable iff (!resetn)
		!q.modem_control_reg[MCR_RTS] |-> rts_n) else $error("request line without modem bit");
	a_dma_single: assert property (@(posedge ref_clk) disable iff (!resetn)
		!q.fifo_control_reg[FCR_DMA_MODE] && push |=> !tx_dma_request) else $error("single dma stuck");
	a_dma_full: assert property (@(posedge ref_clk) disable iff (!resetn)
		q.fifo_control_reg[FCR_DMA_MODE] && q.cnt == (AW+1)'(DEPTH) |-> !tx_dma_request)
		else $error("burst dma at full");

endmodule : utf_tx

// ### testbench/utf_remote_model.sv
/*
 remote serial receiver: decodes 8 data bit, no parity, one stop bit frames on sout.
 assumes the transmitter runs with divisor 1, so one bit is 16 cycles of ref_clk.
*/
// ==========================================
// remote receiver
module utf_remote_model
(
	// clock
	input wire logic ref_clk,
	// line
	input wire logic sout,
	// decoded character
	output logic [7:0] got,
	output logic got_valid,
	output logic frame_bad
);
	initial
	begin
		got = 8'h00;
		got_valid = 1'b0;
		frame_bad = 1'b0;
		forever
		begin
			@(negedge sout);
			// sample mid-bit so a bit time off by one cycle still shows up over a frame
			repeat (8) @(posedge ref_clk);
			if (sout !== 1'b0) frame_bad = 1'b1;
			for (int i = 0; i < 8; i++)
			begin
				repeat (16) @(posedge ref_clk);
				got[i] = sout;
			end
			repeat (16) @(posedge ref_clk);
			if (sout !== 1'b1) frame_bad = 1'b1;
			got_valid <= 1'b1;
			@(posedge ref_clk);
			got_valid <= 1'b0;
		end
	end
endmodule : utf_remote_model

// ### testbench/tb_utf_tx.sv
/*
 self-checking bench for the transmit path: apb master, receive-path stimulus, cts pin.
 assumes zero-wait apb, divisor 1 and 8n1 framing after reset.
*/
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
// ==========================================
// bench top
module tb_utf_tx;
	timeunit 1ns;
	timeprecision 1ps;
	import utf_pkg::*;
	logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, rx_char_keep;
	logic cts_n, sout, rts_n, tx_dma_request, interrupt_out, got_valid, frame_bad;
	logic [7:0] paddr, got, e;
	logic [31:0] pwdata, prdata, rd;
	logic [6:0] rx_count;
	logic [1:0] rx_trig_sel;
	utf_char_type rx_char;
	int failures, checks;
	logic [7:0] exp_q[$];
	logic [1:0] trig;
	logic [6:0] xoff_at [4] = '{7'd8, 7'd16, 7'd56, 7'd60};
	logic [6:0] xon_at [4] = '{7'd0, 7'd8, 7'd16, 7'd56};
	logic [6:0] rts_at [4] = '{7'd16, 7'd56, 7'd60, 7'd60};

	utf_tx #(.DEPTH(64), .DEEP(1'b1)) utf_tx_i (.ref_clk, .resetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .rx_char, .rx_count, .rx_trig_sel,
		.rx_char_keep, .cts_n, .sout, .rts_n, .tx_dma_request, .interrupt_out);
	utf_remote_model utf_remote_model_i (.ref_clk, .sout, .got, .got_valid, .frame_bad);

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
			@(posedge ref_clk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task automatic send(input logic [7:0] d);
		exp_q.push_back(d);
		apb(1'b1, ADDR_HOLD, {24'h000000, d});
	endtask : send

	task automatic drain(input int lim);
		int n = 0;
		while (exp_q.size() != 0 && n < lim)
		begin
			n++;
			@(posedge ref_clk);
		end
		if (n == lim) failures++;
		repeat (20) @(posedge ref_clk);
	endtask : drain

	task automatic rx(input logic [7:0] c, input logic k);
		rx_char <= '{data: c, valid: 1'b1};
		@(negedge ref_clk);
		`CHK(rx_char_keep, k)
		@(posedge ref_clk);
		rx_char <= '0;
		@(posedge ref_clk);
	endtask : rx

	task automatic end_of_test;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// frames are compared in the order they were queued
	always @(posedge ref_clk)
		if (got_valid === 1'b1)
		begin
			`CHK(exp_q.size() > 0, 1'b1)
			if (exp_q.size() > 0)
			begin
				e = exp_q.pop_front();
				`CHK(got, e)
			end
		end

	initial
	begin
		repeat (40000) @(posedge ref_clk);
		failures++;
		end_of_test();
	end

	initial
	begin
		{resetn, psel, penable, pwrite, cts_n} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		rx_count = 7'h04;
		rx_trig_sel = 2'h0;
		rx_char = '0;
		failures = 0;
		checks = 0;
		void'($urandom(22));
		repeat (4) @(posedge ref_clk);
		`CHK({sout, rts_n, interrupt_out}, 3'h6)
		`CHK(tx_dma_request, 1'b1)
		resetn <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, ADDR_RES1 + 8'(4 * i), 32'h0);
			`CHK(rd[7:0], CHAR_RESET)
		end
		apb(1'b0, 8'h3C, 32'h0);
		`CHK(rd, 32'h00000000)
		$display("test reset done");
		apb(1'b1, ADDR_IER, 32'h02);
		repeat (3) @(posedge ref_clk);
		`CHK(interrupt_out, 1'b1)
		apb(1'b0, ADDR_IIR, 32'h0);
		`CHK(rd[IIR_THR], 1'b1)
		`CHK(interrupt_out, 1'b0)
		send(8'($urandom));
		repeat (20) @(posedge ref_clk);
		apb(1'b0, ADDR_LSR, 32'h0);
		`CHK(rd[LSR_TEMT:LSR_THRE], 2'h1)
		`CHK(interrupt_out, 1'b1)
		drain(2000);
		apb(1'b0, ADDR_LSR, 32'h0);
		`CHK(rd[LSR_TEMT], 1'b1)
		$display("test holding flags done");
		apb(1'b1, ADDR_EFR, 32'h80);
		apb(1'b1, ADDR_IER, 32'h80);
		apb(1'b0, ADDR_IIR, 32'h0);
		`CHK(interrupt_out, 1'b0)
		cts_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		`CHK(interrupt_out, 1'b1)
		apb(1'b0, ADDR_IIR, 32'h0);
		`CHK(rd[IIR_FLOW], 1'b1)
		send(8'($urandom));
		repeat (400) @(posedge ref_clk);
		`CHK({sout, exp_q.size() == 1}, 2'h3)
		cts_n <= 1'b0;
		drain(2000);
		send(8'($urandom));
		repeat (40) @(posedge ref_clk);
		cts_n <= 1'b1;
		drain(2000);
		cts_n <= 1'b0;
		apb(1'b0, ADDR_IIR, 32'h0);
		$display("test clear-to-send done");
		trig = 2'($urandom);
		rx_trig_sel <= trig;
		apb(1'b1, ADDR_PAU1, 32'h13);
		apb(1'b1, ADDR_PAU2, 32'h93);
		apb(1'b1, ADDR_RES1, 32'h11);
		apb(1'b1, ADDR_RES2, 32'h91);
		apb(1'b1, ADDR_IER, 32'h20);
		apb(1'b1, ADDR_EFR, 32'h02);
		exp_q.push_back(8'h13);
		exp_q.push_back(8'h93);
		rx_count <= xoff_at[trig];
		drain(2000);
		exp_q.push_back(8'h11);
		exp_q.push_back(8'h91);
		rx_count <= xon_at[trig];
		drain(2000);
		rx_count <= 7'd4;
		rx(8'h41, 1'b1);
		`CHK(interrupt_out, 1'b0)
		rx(8'h13, 1'b0);
		send(8'($urandom));
		repeat (400) @(posedge ref_clk);
		`CHK({sout, interrupt_out, exp_q.size() == 1}, 3'h7)
		rx(8'h91, 1'b0);
		drain(2000);
		apb(1'b0, ADDR_IIR, 32'h0);
		`CHK(rd[IIR_SPECIAL], 1'b0)
		apb(1'b1, ADDR_EFR, 32'h00);
		apb(1'b1, ADDR_IER, 32'h00);
		$display("test pause and resume done");
		apb(1'b1, ADDR_MCR, 32'h02);
		apb(1'b1, ADDR_EFR, 32'h40);
		`CHK(rts_n, 1'b0)
		rx_count <= rts_at[trig];
		repeat (2) @(posedge ref_clk);
		`CHK(rts_n, 1'b1)
		rx_count <= xon_at[trig];
		repeat (2) @(posedge ref_clk);
		`CHK(rts_n, 1'b0)
		$display("test request line done");
		apb(1'b1, ADDR_FCR, 32'h39);
		`CHK(tx_dma_request, 1'b1)
		send(8'($urandom));
		repeat (20) @(posedge ref_clk);
		// hold the shifter with clear-to-send so the fifo really fills
		apb(1'b1, ADDR_EFR, 32'h80);
		cts_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		repeat (64) send(8'($urandom));
		`CHK(tx_dma_request, 1'b0)
		apb(1'b1, ADDR_HOLD, 32'hA5);
		cts_n <= 1'b0;
		drain(12000);
		`CHK(tx_dma_request, 1'b1)
		`CHK(frame_bad, 1'b0)
		$display("test fifo burst done");
		end_of_test();
	end
endmodule : tb_utf_tx
